/* File: hdl/qdac_map.vh */
// Constants for the quad converter serial update logic
// What this block does
// - A 16-bit shift register receives the channel select, update mode, power-down and code.
// - The two mode bits choose between writing a holding register only, updating one output, updating all four outputs at once, or power-down.
// - After reset every channel output is zero until the first complete update-one or update-all write; hold and power-down words leave the outputs alone.
// - A power-down word with a nonzero select field powers the outputs down with one of three output terminations.
// - While frame sync is low, each of the first sixteen falling serial clock edges shifts one data bit in.
// - The shift register runs only while frame sync is low; other clock edges are ignored.
// - The sixteenth falling serial clock edge of a frame applies the received word.
// - Frame sync rising after at least one but before the sixteenth edge aborts the frame and drops the partial word.
`ifndef QDAC_MAP_VH
`define QDAC_MAP_VH

// ==========================================================
// Word layout
`define QDAC_WORD_W 16
`define QDAC_CODE_W 12
`define QDAC_SEL_MSB 15
`define QDAC_SEL_LSB 14
`define QDAC_MODE_MSB 13
`define QDAC_MODE_LSB 12
`define QDAC_CODE_MSB 11
`define QDAC_CODE_LSB 0
`define QDAC_NUM_CH 4

// ==========================================================
// Frame bit counter
`define QDAC_CNT_W 5
`define QDAC_CNT_ZERO 5'h00
`define QDAC_CNT_ONE 5'h01
`define QDAC_CNT_LAST 5'h0f
`define QDAC_CNT_DONE 5'h10

// ==========================================================
// Update modes
`define QDAC_MODE_HOLD 2'h0
`define QDAC_MODE_UPD_ONE 2'h1
`define QDAC_MODE_UPD_ALL 2'h2
`define QDAC_MODE_PWR_DOWN 2'h3

// ==========================================================
// Power-down terminations, carried in the select field
`define QDAC_TERM_NONE 2'h0
`define QDAC_TERM_1K 2'h1
`define QDAC_TERM_100K 2'h2
`define QDAC_TERM_HIZ 2'h3

// ==========================================================
// Reset values
`define QDAC_CODE_RST 12'h000
`define QDAC_WORD_RST 16'h0000
`define QDAC_SYNC_RST 3'h7
`define QDAC_SCLK_RST 3'h0
`define QDAC_DIN_RST 2'h0
`define QDAC_PD_RST 1'h0
`define QDAC_PULSE_RST 1'h0

`endif

/* File: hdl/qdac_serial_update.v */
// Serial word receiver and channel update logic of the quad converter
`timescale 1ns/1ps
`include "qdac_map.vh"

module qdac_serial_update #(
    parameter WORD_W = `QDAC_WORD_W,
    parameter CODE_W = `QDAC_CODE_W
) (
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rst_n,
    // Serial link pins
    input wire i_sync_n,
    input wire i_sclk,
    input wire i_din,
    // Channel codes
    output wire [CODE_W-1:0] o_channel_a_output,
    output wire [CODE_W-1:0] o_channel_b_output,
    output wire [CODE_W-1:0] o_channel_c_output,
    output wire [CODE_W-1:0] o_channel_d_output,
    // Power state
    output wire o_power_down,
    output wire [1:0] o_term_sel,
    // Frame events
    output wire o_word_strobe,
    output wire o_frame_abort
);

    // A pin edge reaches the frame logic two reference clocks after it
    // happens; a word is applied one clock after its sixteenth falling edge
    // is seen, and o_word_strobe rises together with the new outputs.
    localparam NUM_CH = `QDAC_NUM_CH;

    // ==========================================================
    // Decoding
    // One-hot select of the addressed channel
    function [3:0] qdac_onehot;
        input [1:0] sel;
        begin
            qdac_onehot = 4'h0;
            qdac_onehot[sel] = 1'b1;
        end
    endfunction

    // True when a mode field carries the given update mode
    function qdac_mode_is;
        input [1:0] mode;
        input [1:0] code;
        begin
            qdac_mode_is = (mode == code);
        end
    endfunction

    // ==========================================================
    // Pin synchronisers
    // Stage 0 feeds only stage 1; stage 2 is the previous value for edge detection
    // Each link clock phase must last at least one reference clock or an edge
    // is lost, which caps the usable link clock well below the reference clock.
    // Data passes the same depth as the link clock, so the bit read at a falling
    // edge is the one the pin held when that edge arrived.
    reg [2:0] sync_n_q;
    reg [2:0] sclk_q;
    reg [1:0] din_q;

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_n_q <= `QDAC_SYNC_RST;
            sclk_q <= `QDAC_SCLK_RST;
            din_q <= `QDAC_DIN_RST;
        end else begin
            sync_n_q <= {sync_n_q[1:0], i_sync_n};
            sclk_q <= {sclk_q[1:0], i_sclk};
            din_q <= {din_q[0], i_din};
        end
    end

    wire sync_low = ~sync_n_q[1];
    wire sync_rise = sync_n_q[1] & ~sync_n_q[2];
    wire sclk_fall = sclk_q[2] & ~sclk_q[1];
    wire din_bit = din_q[1];

    // ==========================================================
    // Shift register and bit counter
    reg [WORD_W-1:0] shift_q;
    reg [WORD_W-1:0] shift_d;
    reg [`QDAC_CNT_W-1:0] cnt_q;
    reg [`QDAC_CNT_W-1:0] cnt_d;
    reg apply_d;
    reg abort_d;

    always @* begin
        shift_d = shift_q;
        cnt_d = cnt_q;
        apply_d = 1'b0;
        abort_d = 1'b0;
        if (!sync_low) begin
            // Frame ended; a short frame is dropped
            cnt_d = `QDAC_CNT_ZERO;
            // A frame that never clocked a bit ends without an abort pulse
            if (sync_rise && cnt_q != `QDAC_CNT_DONE && cnt_q != `QDAC_CNT_ZERO) begin
                abort_d = 1'b1;
            end
        end else if (sclk_fall && cnt_q != `QDAC_CNT_DONE) begin
            // The count stops at sixteen, so later edges of the same frame do nothing
            // MSB arrives first and ends at the top
            shift_d = {shift_q[WORD_W-2:0], din_bit};
            cnt_d = cnt_q + `QDAC_CNT_ONE;
            if (cnt_q == `QDAC_CNT_LAST) begin
                apply_d = 1'b1;
            end
        end
    end

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_q <= `QDAC_WORD_RST;
            cnt_q <= `QDAC_CNT_ZERO;
        end else begin
            shift_q <= shift_d;
            cnt_q <= cnt_d;
        end
    end

    // ==========================================================
    // Word fields
    // Taken from the next-state word so that the sixteenth bit is included
    wire [1:0] w_sel = shift_d[`QDAC_SEL_MSB:`QDAC_SEL_LSB];
    wire [1:0] w_mode = shift_d[`QDAC_MODE_MSB:`QDAC_MODE_LSB];
    wire [CODE_W-1:0] w_code = shift_d[`QDAC_CODE_MSB:`QDAC_CODE_LSB];
    wire [3:0] w_hit = qdac_onehot(w_sel);

    wire is_pwr = qdac_mode_is(w_mode, `QDAC_MODE_PWR_DOWN);
    wire is_all = qdac_mode_is(w_mode, `QDAC_MODE_UPD_ALL);
    wire is_one = qdac_mode_is(w_mode, `QDAC_MODE_UPD_ONE);

    // ==========================================================
    // Holding and output registers, one pair per channel
    // In update-all mode every other output loads its holding register and the addressed one takes the new code,
    // so codes written earlier with the hold mode appear on all outputs at once
    wire [CODE_W*NUM_CH-1:0] out_bus;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_chan
            reg [CODE_W-1:0] hold_q;
            reg [CODE_W-1:0] out_q;
            // Every mode but power-down writes the addressed holding register
            wire wr_hold = apply_d && !is_pwr && w_hit[ch];
            wire ld_all = apply_d && is_all;
            wire ld_one = apply_d && is_one && w_hit[ch];

            always @(posedge i_ref_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    hold_q <= `QDAC_CODE_RST;
                    out_q <= `QDAC_CODE_RST;
                end else begin
                    if (wr_hold) begin
                        hold_q <= w_code;
                    end
                    if (ld_all) begin
                        // All outputs move together; the addressed one takes the new code
                        out_q <= w_hit[ch] ? w_code : hold_q;
                    end else if (ld_one) begin
                        out_q <= w_code;
                    end
                end
            end

            assign out_bus[ch*CODE_W +: CODE_W] = out_q;
        end
    endgenerate

    assign o_channel_a_output = out_bus[0*CODE_W +: CODE_W];
    assign o_channel_b_output = out_bus[1*CODE_W +: CODE_W];
    assign o_channel_c_output = out_bus[2*CODE_W +: CODE_W];
    assign o_channel_d_output = out_bus[3*CODE_W +: CODE_W];

    // ==========================================================
    // Power-down state
    reg pd_q;
    reg [1:0] term_q;

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pd_q <= `QDAC_PD_RST;
            term_q <= `QDAC_TERM_NONE;
        end else if (apply_d) begin
            if (is_pwr) begin
                // A power-down word without a termination leaves the state alone
                if (w_sel != `QDAC_TERM_NONE) begin
                    pd_q <= 1'b1;
                    term_q <= w_sel;
                end
            end else if (is_one || is_all) begin
                // An output update wakes the outputs
                pd_q <= 1'b0;
                term_q <= `QDAC_TERM_NONE;
            end
        end
    end

    assign o_power_down = pd_q;
    assign o_term_sel = term_q;

    // ==========================================================
    // Frame event pulses
    // Registered so that each pulse lines up with the state it reports
    reg strobe_q;
    reg abort_q;

    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strobe_q <= `QDAC_PULSE_RST;
            abort_q <= `QDAC_PULSE_RST;
        end else begin
            strobe_q <= apply_d;
            abort_q <= abort_d;
        end
    end

    assign o_word_strobe = strobe_q;
    assign o_frame_abort = abort_q;

endmodule

/* File: sim/qdac_host_model.sv */
// Host serial master driving frame sync, link clock and data
`timescale 1ns/1ps
module qdac_host_model (
    // Clock
    input wire i_ref_clk,
    // Serial link pins
    output reg o_sync_n,
    output reg o_sclk,
    output reg o_din
);
    integer i;
    initial begin
        o_sync_n = 1'b1;
        o_sclk = 1'b1;
        o_din = 1'b0;
    end
    // Five cycles a phase gives an 80 ns link clock
    task half;
        repeat (5) @(negedge i_ref_clk);
    endtask
    task send(input [15:0] w, input integer n);
        o_sync_n = 1'b0;
        for (i = 0; i < n; i = i + 1) begin
            o_din = w[15-i];
            half;
            o_sclk = 1'b0;
            half;
            o_sclk = 1'b1;
        end
        half;
        o_sync_n = 1'b1;
        o_din = ~o_din;
        half;
        half;
    endtask
    task stray(input integer n);
        for (i = 0; i < n; i = i + 1) begin
            half;
            o_sclk = 1'b0;
            half;
            o_sclk = 1'b1;
        end
    endtask
endmodule

/* File: sim/qdac_serial_update_props.sv */
// Concurrent checks on the quad converter serial update ports
`timescale 1ns/1ps
module qdac_serial_update_props #(
    parameter CODE_W = 12
) (
    // Clock and reset
    input wire i_ref_clk,
    input wire i_rst_n,
    // Serial link pins
    input wire i_sync_n,
    input wire i_sclk,
    input wire i_din,
    // Outputs
    input wire [CODE_W-1:0] o_channel_a_output,
    input wire [CODE_W-1:0] o_channel_b_output,
    input wire [CODE_W-1:0] o_channel_c_output,
    input wire [CODE_W-1:0] o_channel_d_output,
    input wire o_power_down,
    input wire [1:0] o_term_sel,
    input wire o_word_strobe,
    input wire o_frame_abort
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    wire [4*CODE_W-1:0] codes = {o_channel_a_output, o_channel_b_output,
        o_channel_c_output, o_channel_d_output};
    property p_strobe_pulse; o_word_strobe |=> !o_word_strobe; endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("long strobe");
    property p_abort_pulse; o_frame_abort |=> !o_frame_abort; endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("long abort");
    property p_codes_hold; $changed(codes) |-> o_word_strobe; endproperty
    a_codes_hold: assert property (p_codes_hold) else $error("code moved");
    property p_pd_hold; $changed({o_power_down, o_term_sel}) |-> o_word_strobe; endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("power moved");
    property p_awake_term; !o_power_down |-> o_term_sel == 2'h0; endproperty
    a_awake_term: assert property (p_awake_term) else $error("term while awake");
    property p_down_term; o_power_down |-> o_term_sel != 2'h0; endproperty
    a_down_term: assert property (p_down_term) else $error("no term while down");
    property p_strobe_sync; o_word_strobe |-> !$past(i_sync_n, 3) && !$past(i_sclk, 3)
        && $past(i_sclk, 4); endproperty
    a_strobe_sync: assert property (p_strobe_sync) else $error("strobe off frame");
    property p_abort_excl; o_frame_abort |-> !o_word_strobe && $stable(codes); endproperty
    a_abort_excl: assert property (p_abort_excl) else $error("abort applied");
    property p_abort_cause; o_frame_abort |-> $past(i_sync_n, 3) && !$past(i_sync_n, 4);
        endproperty
    a_abort_cause: assert property (p_abort_cause) else $error("abort no rise");
endmodule

bind qdac_serial_update qdac_serial_update_props #(.CODE_W(CODE_W)) u_props (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_sync_n(i_sync_n),
    .i_sclk(i_sclk),
    .i_din(i_din),
    .o_channel_a_output(o_channel_a_output),
    .o_channel_b_output(o_channel_b_output),
    .o_channel_c_output(o_channel_c_output),
    .o_channel_d_output(o_channel_d_output),
    .o_power_down(o_power_down),
    .o_term_sel(o_term_sel),
    .o_word_strobe(o_word_strobe),
    .o_frame_abort(o_frame_abort)
);

/* File: sim/testbench.sv */
// Self-checking bench for the quad converter serial update logic
`timescale 1ns/1ps
`define CHK(x, y) begin n_compared++; if ((x) !== (y)) begin err_count++; \
    $display("BAD %0t mismatch %h", $time, (x)); end end
module testbench;
    reg i_ref_clk = 1'b0;
    reg i_rst_n = 1'b0;
    reg [1:0] k;
    wire sync_n, sclk, din, pd, strobe, abort;
    wire [11:0] a, b, c, d;
    wire [1:0] term;
    integer err_count = 0, n_compared = 0, n_strobe = 0, n_abort = 0, cycles = 0;
    initial forever #4 i_ref_clk = ~i_ref_clk;
    qdac_host_model host (.i_ref_clk(i_ref_clk), .o_sync_n(sync_n), .o_sclk(sclk), .o_din(din));
    qdac_serial_update dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_sync_n(sync_n),
        .i_sclk(sclk), .i_din(din), .o_channel_a_output(a), .o_channel_b_output(b),
        .o_channel_c_output(c), .o_channel_d_output(d), .o_power_down(pd),
        .o_term_sel(term), .o_word_strobe(strobe), .o_frame_abort(abort));
    task conclude;
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task outs(input [47:0] e);
        `CHK({a, b, c, d}, e)
    endtask
    always @(posedge i_ref_clk) begin
        cycles++;
        n_strobe += (strobe === 1'b1);
        n_abort += (abort === 1'b1);
        if (cycles == 10000) begin
            err_count++;
            conclude;
        end
    end
    initial begin
        repeat (3) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        outs({48{1'b0}});
        host.send(16'h1abc, 16);
        outs({12'habc, 36'h0_0000_0000});
        host.send(16'h4123, 16);
        host.send(16'h9456, 16);
        outs({12'habc, 12'h000, 12'h456, 12'h000});
        host.send(16'he789, 16);
        outs({48'habc1_2345_6789});
        host.send(16'h1fff, 10);
        `CHK(n_abort, 1)
        host.stray(20);
        outs({48'habc1_2345_6789});
        for (k = 2'h1; k != 2'h0; k++) begin
            host.send({k, 14'h3000}, 16);
            `CHK({pd, term}, {1'b1, k})
        end
        host.send(16'h3000, 16);
        `CHK({pd, term}, 3'h7)
        host.send(16'h1000, 16);
        `CHK({pd, term, a}, 15'h0000)
        `CHK(n_strobe, 9)
        i_rst_n = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        `CHK({a, b, c, d, pd, term}, 51'h0)
        host.send(16'h6555, 16);
        outs({12'h000, 12'h555, 24'h00_0000});
        `CHK(n_strobe, 10)
        conclude;
    end
endmodule
